/* File: core/rsq_pkg.sv */
// Constants and types shared by the reset initial-state block
package rsq_pkg;

  typedef enum logic [2:0] {
    ST_DRIVE    = 3'h0,
    ST_SAMPLE   = 3'h1,
    ST_FETCH_HI = 3'h3,
    ST_FETCH_LO = 3'h2,
    ST_FETCH_GO = 3'h6,
    ST_RUN      = 3'h7,
    ST_HOLD     = 3'h5
  } rsq_state_type;

  typedef enum logic [1:0] {
    CAUSE_EXT      = 2'h0,
    CAUSE_CLK_FAIL = 2'h1,
    CAUSE_WDOG     = 2'h2,
    CAUSE_POWER    = 2'h3
  } rsq_cause_type;

  typedef struct packed {
    logic boot_rom_read_enable;
    logic special_mode_bit;
    logic mode_a_bit;
  } rsq_mode_type;

  typedef struct packed {
    logic [15:0] addr;
    logic        valid;
  } rsq_fetch_type;

  // Sequencer timing: MCLK cycles per bus (E) cycle, then step lengths in E cycles
  localparam int       RSQ_E_DIV           = 4;
  localparam logic [2:0] RSQ_DRIVE_E_CYCLES  = 3'h4;
  localparam logic [2:0] RSQ_SAMPLE_E_CYCLES = 3'h2;

  // Vector bytes
  localparam logic [7:0] RSQ_VEC_HI_NORMAL  = 8'hff;
  localparam logic [7:0] RSQ_VEC_HI_SPECIAL = 8'hbf;
  localparam logic [7:0] RSQ_VEC_LO_EXT     = 8'hfe;
  localparam logic [7:0] RSQ_VEC_LO_CLK     = 8'hfc;
  localparam logic [7:0] RSQ_VEC_LO_WDOG    = 8'hfa;

  // Register indices
  localparam int RSQ_ADDR_W = 6;
  localparam int RSQ_NREG   = 35;
  localparam logic [5:0] RSQ_IDX_COND_FLAGS = 6'h00;
  localparam logic [5:0] RSQ_IDX_MEM_MAP    = 6'h01;
  localparam logic [5:0] RSQ_IDX_PIO_CTRL   = 6'h02;
  localparam logic [5:0] RSQ_IDX_PORTC_DIR  = 6'h03;
  localparam logic [5:0] RSQ_IDX_PORTB_DATA = 6'h04;
  localparam logic [5:0] RSQ_IDX_PORTA_DATA = 6'h05;
  localparam logic [5:0] RSQ_IDX_SER_STATUS = 6'h14;
  localparam logic [5:0] RSQ_IDX_PRIORITY   = 6'h17;
  localparam logic [5:0] RSQ_IDX_RST_STATUS = 6'h23;
  localparam logic [5:0] RSQ_IDX_NV_STATUS  = 6'h24;

  // Field positions
  localparam int RSQ_BIT_GLOBAL_MASK = 4;
  localparam int RSQ_BIT_PORTA_LO    = 3;

  localparam logic [3:0] RSQ_PSEL_RESET = 4'h5;

  // Reset value of every stored register, by index
  localparam logic [7:0] RSQ_RESET_VALUE [RSQ_NREG] = '{
    8'hd0, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'h00, 8'h00, 8'h05,
    8'h10, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff
  };

endpackage

/* File: core/rsq_reset_init.sv */
// Reset sequencer and initial-state register file of the microcontroller
//
// Contract
// [RULE1] Three cycles fetch start vector, then run
// [RULE2] Reset sets both interrupt masks, stop-disable
// [RULE3] Memory map: RAM 0000, registers 1000
// [RULE4] Nonvolatile ROM and EEPROM enables survive reset
// [RULE5] Port B shows FF expanded, 00 single-chip
// [RULE6] Clocked reset steps; no clock, no exit
// [RULE7] Reset clears clock divider without clock
// [RULE8] Expanded mode gives handshake pins to bus
// [RULE9] Single-chip: parallel control cleared, rising edge
// [RULE10] Port B, port A 6-3 drive zero
// [RULE11] Timer count zero, compares all FFFF
// [RULE12] Timer masks, flags, captures all cleared
// [RULE13] Periodic interrupt flag, mask, rate cleared
// [RULE14] Pulse counter and sync serial disabled
// [RULE15] Watchdog enable from nonvolatile bit, shortest
// [RULE16] Async serial off, 8-bit, no break
// [RULE17] Transmit status set, receive status cleared
// [RULE18] Converter flag and power bit cleared
// [RULE19] EEPROM programming off, priority 0101, level
// [RULE20] Mode bits latched; delay set, monitor off
// [RULE21] Any source resets all, pin low
// [RULE22] Priority register written only when masked
// [RULE23] Mode pins captured through clocked pipeline
// [RULE24] Clock-fail and watchdog vectors differ
// [RULE25] Internal reset drives pin, samples later
// [RULE26] Reset values held until sequence releases
`timescale 1ns/100ps
`default_nettype none

module rsq_reset_init
  import rsq_pkg::*;
#(
  parameter int E_DIV = RSQ_E_DIV
) (
  // Clock and power-on reset
  input  wire logic                  MCLK,
  input  wire logic                  RESET_N,
  // Two-way reset pin
  input  wire logic                  RST_PIN_I,
  output logic                       RST_PIN_O,
  output logic                       RST_PIN_OE_N,
  // Internal reset requests
  input  wire logic                  CLK_FAIL_REQ,
  input  wire logic                  WDOG_TIMEOUT_REQ,
  // Mode pins and nonvolatile options
  input  wire logic                  MODE_PIN_A,
  input  wire logic                  MODE_PIN_B,
  input  wire logic                  ROM_ENABLE_NV,
  input  wire logic                  EEPROM_ENABLE_NV,
  input  wire logic                  WATCHDOG_DISABLE_BIT,
  // Register port
  input  wire logic [RSQ_ADDR_W-1:0] REG_ADDR,
  input  wire logic [7:0]            REG_WDATA,
  input  wire logic                  REG_WR,
  input  wire logic                  REG_RD,
  output logic      [7:0]            REG_RDATA,
  // Sequencer and system state
  output logic                       E_TICK,
  output logic                       RESET_ACTIVE,
  output rsq_fetch_type              FETCH,
  output logic                       CPU_RUN,
  output rsq_mode_type               MODE,
  output logic                       EXPANSION_BUS_EN,
  output logic                       WDOG_ENABLE,
  // Port pins
  output logic      [7:0]            PORT_B_OUT,
  output logic      [3:0]            PORT_A_OUT,
  output logic      [7:0]            PORT_C_DIR
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  rsq_state_type state;
  rsq_cause_type cause;
  logic [2:0]    seq_cnt;
  logic [7:0]    e_cnt;
  logic          e_tick;
  logic          in_reset;
  logic          int_req;
  logic          leave_reset;
  logic          seq_last;
  logic [1:0]    mode_p1;
  logic [1:0]    mode_p2;
  rsq_mode_type  mode;
  rsq_mode_type  next_mode;
  logic [7:0]    regs [RSQ_NREG];
  logic [7:0]    rd_mux;
  logic [7:0]    vec_hi;
  logic [7:0]    vec_lo;
  logic [15:0]   drv_cyc;

  assign in_reset = (state != ST_RUN);
  assign int_req  = (CLK_FAIL_REQ || WDOG_TIMEOUT_REQ)
                    && (state inside {ST_FETCH_HI, ST_FETCH_LO,
                                      ST_FETCH_GO, ST_RUN});
  assign seq_last = (state == ST_DRIVE) ? (seq_cnt == RSQ_DRIVE_E_CYCLES - 3'h1)
                                        : (seq_cnt == RSQ_SAMPLE_E_CYCLES - 3'h1);
  assign leave_reset = ((state == ST_HOLD) && RST_PIN_I)
                       || ((state == ST_SAMPLE) && e_tick && seq_last && RST_PIN_I);

  //////////////////////////////////////////////////////////////////////////////
  // Bus-cycle divider

  assign e_tick = (e_cnt == 8'(E_DIV - 1));

  // The asynchronous clear lets the oscillator restart with no clock present
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      e_cnt <= 8'h00; // RULE7
    end else if (int_req || ((state == ST_HOLD) && !RST_PIN_I)) begin
      e_cnt <= 8'h00; // RULE7
    end else if (e_tick) begin
      e_cnt <= 8'h00;
    end else begin
      e_cnt <= e_cnt + 8'h01;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      E_TICK <= 1'b0;
    end else begin
      E_TICK <= e_tick;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reset sequencer

  // Power-on starts in the drive step; without a clock it never leaves it
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state   <= ST_DRIVE; // RULE6
      cause   <= CAUSE_POWER;
      seq_cnt <= 3'h0;
    end else if (int_req) begin
      state   <= ST_DRIVE; // RULE21 RULE25
      cause   <= CLK_FAIL_REQ ? CAUSE_CLK_FAIL : CAUSE_WDOG;
      seq_cnt <= 3'h0;
    end else begin
      unique case (state)
        ST_DRIVE: begin
          if (e_tick) begin
            seq_cnt <= seq_last ? 3'h0 : seq_cnt + 3'h1;
            if (seq_last) begin
              state <= ST_SAMPLE; // RULE25
            end
          end
        end
        ST_SAMPLE: begin
          if (e_tick) begin
            seq_cnt <= seq_last ? 3'h0 : seq_cnt + 3'h1;
            if (seq_last && !RST_PIN_I) begin
              // Pin still low: someone outside holds reset
              state <= ST_HOLD; // RULE25
              cause <= CAUSE_EXT;
            end else if (seq_last) begin
              state <= ST_FETCH_HI;
            end
          end
        end
        ST_HOLD: begin
          if (RST_PIN_I) begin
            state <= ST_FETCH_HI; // RULE6
          end
        end
        ST_FETCH_HI, ST_FETCH_LO, ST_FETCH_GO, ST_RUN: begin
          if (!RST_PIN_I) begin
            state <= ST_HOLD; // RULE21
            cause <= CAUSE_EXT;
          end else if (state == ST_FETCH_HI) begin
            state <= ST_FETCH_LO; // RULE1
          end else if (state == ST_FETCH_LO) begin
            state <= ST_FETCH_GO; // RULE1
          end else begin
            state <= ST_RUN; // RULE1
          end
        end
        default: begin
          state <= ST_DRIVE;
        end
      endcase
    end
  end

  // Only the drive step pulls the pin; an outside low is just observed
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RST_PIN_OE_N <= 1'b0;
    end else begin
      RST_PIN_OE_N <= !(int_req || ((state == ST_DRIVE)
                        && !(e_tick && seq_last))); // RULE25
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RST_PIN_O <= 1'b0;
    end else begin
      RST_PIN_O <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mode pipeline and latch

  // Two stages give zero hold time on the mode pins at reset release
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_p1 <= 2'h0;
      mode_p2 <= 2'h0;
    end else begin
      mode_p1 <= {MODE_PIN_B, MODE_PIN_A}; // RULE23
      mode_p2 <= mode_p1;
    end
  end

  always_comb begin
    next_mode.boot_rom_read_enable = !mode_p2[1] && !mode_p2[0]; // RULE23
    next_mode.special_mode_bit     = !mode_p2[1];
    next_mode.mode_a_bit           = mode_p2[0];
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode <= '0;
    end else if (leave_reset) begin
      mode <= next_mode; // RULE20
    end
  end

  assign MODE = mode;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      EXPANSION_BUS_EN <= 1'b0;
    end else begin
      EXPANSION_BUS_EN <= mode.mode_a_bit; // RULE8
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Vector fetch

  assign vec_hi = mode.special_mode_bit ? RSQ_VEC_HI_SPECIAL
                                        : RSQ_VEC_HI_NORMAL; // RULE1
  assign vec_lo = (cause == CAUSE_CLK_FAIL) ? RSQ_VEC_LO_CLK
                : (cause == CAUSE_WDOG)     ? RSQ_VEC_LO_WDOG
                                            : RSQ_VEC_LO_EXT; // RULE24

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FETCH   <= '0;
      CPU_RUN <= 1'b0;
    end else begin
      FETCH.valid <= (state == ST_FETCH_HI) || (state == ST_FETCH_LO); // RULE1
      FETCH.addr  <= {vec_hi, vec_lo[7:1], (state == ST_FETCH_LO)};
      CPU_RUN     <= (state == ST_RUN) && RST_PIN_I && !int_req;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RESET_ACTIVE <= 1'b1;
    end else begin
      // Raised on the edge a request is taken, when the registers are forced
      RESET_ACTIVE <= in_reset || int_req || !RST_PIN_I; // RULE21 RULE26
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register file

  // Every stored register is forced to its start value for the whole
  // sequence, so software writes only land once the core is running
  for (genvar i = 0; i < RSQ_NREG; i++) begin : g_reg
    logic [7:0] rst_val;
    logic       wr_hit;
    logic [7:0] wr_val;

    if (i == int'(RSQ_IDX_PRIORITY)) begin : g_prio
      assign rst_val = {mode, mode.special_mode_bit, RSQ_PSEL_RESET}; // RULE19 RULE20
      assign wr_val  = {regs[i][7:4], REG_WDATA[3:0]};
      assign wr_hit  = regs[RSQ_IDX_COND_FLAGS][RSQ_BIT_GLOBAL_MASK]; // RULE22
    end else begin : g_plain
      assign rst_val = RSQ_RESET_VALUE[i]; // RULE2 RULE3 RULE9 RULE10 RULE11 RULE12
      assign wr_val  = REG_WDATA;          // RULE13 RULE14 RULE16 RULE17 RULE18
      assign wr_hit  = 1'b1;
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
        regs[i] <= RSQ_RESET_VALUE[i];
      end else if (in_reset || int_req || !RST_PIN_I) begin
        regs[i] <= rst_val; // RULE21 RULE26
      end else if (REG_WR && wr_hit && (REG_ADDR == 6'(i))) begin
        regs[i] <= wr_val;
      end
    end
  end

  // Shortest watchdog rate is the zero reset value of its rate register
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      WDOG_ENABLE <= 1'b0;
    end else if (in_reset) begin
      WDOG_ENABLE <= !WATCHDOG_DISABLE_BIT; // RULE15
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    if (REG_ADDR < 6'(RSQ_NREG)) begin
      rd_mux = regs[REG_ADDR];
    end else if (REG_ADDR == RSQ_IDX_RST_STATUS) begin
      rd_mux = {state, cause, WDOG_ENABLE, 2'h0};
    end else if (REG_ADDR == RSQ_IDX_NV_STATUS) begin
      // Nonvolatile options are never touched by the reset logic
      rd_mux = {5'h00, WATCHDOG_DISABLE_BIT, EEPROM_ENABLE_NV, ROM_ENABLE_NV}; // RULE4
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= REG_RD ? rd_mux : 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Port pins

  // Port B mode is taken from the pipeline, so it is right only once clocked
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PORT_B_OUT <= 8'h00;
      PORT_A_OUT <= 4'h0;
      PORT_C_DIR <= 8'h00;
    end else if (in_reset) begin
      PORT_B_OUT <= mode_p2[0] ? RSQ_VEC_HI_NORMAL : 8'h00; // RULE5
      PORT_A_OUT <= 4'h0;  // RULE10
      PORT_C_DIR <= 8'h00; // RULE9
    end else begin
      PORT_B_OUT <= regs[RSQ_IDX_PORTB_DATA];
      PORT_A_OUT <= regs[RSQ_IDX_PORTA_DATA][RSQ_BIT_PORTA_LO+:4];
      PORT_C_DIR <= regs[RSQ_IDX_PORTC_DIR];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      drv_cyc <= 16'h0000;
    end else begin
      drv_cyc <= (state == ST_DRIVE) ? drv_cyc + 16'h0001 : 16'h0000;
    end
  end

  AST_FETCH_ORDER: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE1
    (state == ST_FETCH_HI) && RST_PIN_I && !int_req |=>
      FETCH.valid && !FETCH.addr[0] ##1 FETCH.valid && FETCH.addr[0] ##1 !FETCH.valid)
    else $error("vector fetch order wrong");

  AST_FETCH_HI_BYTE: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE1
    FETCH.valid |-> FETCH.addr[15:8] ==
      (mode.special_mode_bit ? 8'hbf : 8'hff))
    else $error("vector high byte wrong");

  AST_WDOG_VECTOR: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE24
    (state == ST_FETCH_HI) && (cause == CAUSE_WDOG) |=>
      FETCH.addr[7:0] == 8'hfa)
    else $error("watchdog vector wrong");

  AST_MASKS_SET: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE2
    $rose(state == ST_RUN) |->
      regs[RSQ_IDX_COND_FLAGS][7:6] == 2'h3 && regs[RSQ_IDX_COND_FLAGS][4])
    else $error("interrupt masks not set");

  AST_MEM_MAP: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE3
    $rose(state == ST_RUN) |-> regs[RSQ_IDX_MEM_MAP] == 8'h01)
    else $error("memory map not reset");

  AST_DRIVE_LEN: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE25
    $rose(state == ST_SAMPLE) |-> $past(drv_cyc) == 16'(4 * E_DIV - 1))
    else $error("reset pin drive length wrong");

  AST_HOLD_STAYS: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE6
    (state == ST_HOLD) && !RST_PIN_I |=> (state == ST_HOLD) && (e_cnt == 8'h00))
    else $error("left reset while pin low");

  AST_SERIAL_STATUS: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE17
    in_reset ##1 in_reset |-> regs[RSQ_IDX_SER_STATUS] == 8'hc0)
    else $error("serial status not reset");

  AST_PRIO_GUARD: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE22
    !in_reset && RST_PIN_I && !int_req && REG_WR
      && (REG_ADDR == RSQ_IDX_PRIORITY)
      && !regs[RSQ_IDX_COND_FLAGS][RSQ_BIT_GLOBAL_MASK]
      |=> $stable(regs[RSQ_IDX_PRIORITY]))
    else $error("priority written while unmasked");

  AST_PORT_B_RESET: assert property (@(posedge MCLK) disable iff (!RESET_N) // RULE5
    in_reset && $past(in_reset) |=> PORT_B_OUT == {8{$past(mode_p2[0])}})
    else $error("port B reset level wrong");

endmodule // rsq_reset_init

`default_nettype wire

/* File: tb/rsq_pin_model.sv */
// Board reset circuitry that shares the open-drain reset pin
`timescale 1ns/100ps
`default_nettype none

module rsq_pin_model (
  // Clock
  input  wire logic       MCLK,
  // Device side of the pin
  input  wire logic       dev_o,
  input  wire logic       dev_oe_n,
  // Board side controls
  input  wire logic       ext_low,
  input  wire logic [7:0] linger,
  // Resolved pin level
  output logic            pin
);
  logic [7:0] cnt = 8'h00;
  logic       dev_low;

  assign dev_low = !dev_oe_n && !dev_o;

  // Board capacitance keeps the pin low for a while after the device lets go
  always_ff @(posedge MCLK) begin
    if (dev_low) begin
      cnt <= linger;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end

  // Pull-up: the pin is high unless some party pulls it low
  assign pin = !(dev_low || ext_low || cnt != 8'h00);
endmodule // rsq_pin_model

`default_nettype wire

/* File: tb/rsq_reset_init_tb_top.sv */
// Self-checking bench for the reset initial-state block
`timescale 1ns/100ps
`default_nettype none

module rsq_reset_init_tb_top;
  import rsq_pkg::*;
  // Short bus cycle keeps the reset sequence brief
  localparam int ED = 2;
  logic          mclk = 1'b0;
  logic          reset_n;
  logic          pin;
  logic          pin_o;
  logic          pin_oe_n;
  logic          clk_fail;
  logic          wdog;
  logic          mode_a;
  logic          mode_b;
  logic          rom_nv;
  logic          ee_nv;
  logic          wd_dis;
  logic          ext_low;
  logic [7:0]    linger;
  logic [5:0]    addr;
  logic [7:0]    wdata;
  logic [7:0]    rdata;
  logic          reg_wr;
  logic          reg_rd;
  logic          e_tick;
  logic          rst_act;
  logic          cpu_run;
  logic          exp_bus;
  logic          wd_en;
  rsq_fetch_type fetch;
  rsq_mode_type  mode;
  logic [7:0]    port_b;
  logic [3:0]    port_a;
  logic [7:0]    port_c_dir;
  int            bad_count = 0;
  int            cmp_count = 0;

  always #5 mclk = ~mclk;

  rsq_reset_init #(.E_DIV(ED)) rsq_reset_init_inst (
    .MCLK(mclk), .RESET_N(reset_n), .RST_PIN_I(pin), .RST_PIN_O(pin_o),
    .RST_PIN_OE_N(pin_oe_n), .CLK_FAIL_REQ(clk_fail), .WDOG_TIMEOUT_REQ(wdog),
    .MODE_PIN_A(mode_a), .MODE_PIN_B(mode_b), .ROM_ENABLE_NV(rom_nv),
    .EEPROM_ENABLE_NV(ee_nv), .WATCHDOG_DISABLE_BIT(wd_dis), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata),
    .E_TICK(e_tick), .RESET_ACTIVE(rst_act), .FETCH(fetch), .CPU_RUN(cpu_run),
    .MODE(mode), .EXPANSION_BUS_EN(exp_bus), .WDOG_ENABLE(wd_en),
    .PORT_B_OUT(port_b), .PORT_A_OUT(port_a), .PORT_C_DIR(port_c_dir));

  rsq_pin_model rsq_pin_model_inst (
    .MCLK(mclk), .dev_o(pin_o), .dev_oe_n(pin_oe_n), .ext_low(ext_low),
    .linger(linger), .pin(pin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timeout(input string what);
    bad_count++;
    $display("[ERR] %s expected done seen timeout", what);
    end_sim();
  endtask

  task automatic bus_wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic boot(input logic [15:0] vec);
    int n;
    n = 0;
    while (fetch.valid !== 1'b1) begin
      @(posedge mclk);
      #1;
      n++;
      if (n > 300) timeout("fetch");
    end
    chk("fetch hi", vec, fetch.addr);
    chk("fetch in reset", 1'b1, rst_act);
    @(posedge mclk);
    #1;
    chk("fetch lo", vec | 16'h0001, {fetch.addr[15:1], fetch.addr[0] & fetch.valid});
    @(posedge mclk);
    #1;
    chk("fetch end", 1'b0, fetch.valid);
    @(posedge mclk);
    #1;
    chk("run", 2'b10, {cpu_run, rst_act});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic por(input logic b, input logic a, input logic wdd);
    @(posedge mclk);
    reset_n <= 1'b0;
    mode_b <= b;
    mode_a <= a;
    wd_dis <= wdd;
    repeat (2) @(posedge mclk);
    #1;
    chk("pin in reset", 2'b10, {rst_act, pin});
    @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk("port b", a ? 8'hff : 8'h00, port_b);
    chk("port a", 4'h0, port_a);
    chk("bus tick", 1'b1, e_tick);
    boot({b ? 8'hff : 8'hbf, 8'hfe});
    chk("mode", {!b && !a, !b, a}, mode);
    chk("bus", a, exp_bus);
    chk("watchdog", !wdd, wd_en);
    $display("power reset b=%0b a=%0b done", b, a);
  endtask

  task automatic t_regs();
    logic [7:0] d;
    logic [7:0] e;
    for (int i = 0; i <= 'h22; i++) begin
      e = (i >= 'h19) ? 8'hff : (i == 0) ? 8'hd0 : (i == 1) ? 8'h01 : (i == 2) ? 8'h02
        : (i == 'h14) ? 8'hc0 : (i == 'h18) ? 8'h10 : 8'h00;
      bus_rd(6'(i), d);
      if (i != 'h17) chk("reset reg", e, d);
    end
    bus_rd(6'h17, d);
    chk("priority", {!mode_b && !mode_a, !mode_b, mode_a, !mode_b, 4'h5}, d);
    bus_rd(6'h24, d);
    chk("options", {5'h00, wd_dis, ee_nv, rom_nv}, d);
    chk("port c dir", 8'h00, port_c_dir);
    $display("t_regs done");
  endtask

  task automatic t_writes();
    logic [7:0] d;
    bus_wr(6'h17, 8'h03);
    bus_rd(6'h17, d);
    chk("priority write", 4'h3, d[3:0]);
    bus_wr(6'h00, 8'h00);
    bus_wr(6'h17, 8'h09);
    bus_rd(6'h17, d);
    chk("priority unmasked", 4'h3, d[3:0]);
    bus_wr(6'h24, 8'hf8);
    bus_rd(6'h24, d);
    chk("options read-only", {5'h00, wd_dis, ee_nv, rom_nv}, d);
    bus_wr(6'h30, 8'h5a);
    bus_rd(6'h30, d);
    chk("unmapped", 8'h00, d);
    bus_wr(6'h03, 8'hff);
    @(posedge mclk);
    #1;
    chk("port c write", 8'hff, port_c_dir);
    @(posedge mclk);
    ext_low <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk("external hold", 9'h100, {rst_act, port_c_dir});
    bus_wr(6'h03, 8'hff);
    @(posedge mclk);
    ext_low <= 1'b0;
    boot(16'hfffe);
    bus_rd(6'h03, d);
    chk("write in reset", 8'h00, d);
    $display("t_writes done");
  endtask

  // The linger count decides whether the pin is seen high at the late sample
  task automatic t_int(input logic cf, input logic wd, input logic [7:0] lg,
                       input logic [15:0] vec);
    int n;
    logic [7:0] d;
    @(posedge mclk);
    linger <= lg;
    clk_fail <= cf;
    wdog <= wd;
    @(posedge mclk);
    clk_fail <= 1'b0;
    wdog <= 1'b0;
    #1;
    chk("pin drive", 3'b010, {pin_oe_n, rst_act, cpu_run});
    n = 0;
    while (pin_oe_n === 1'b0 && n < 100) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("drive length", 16'(4 * ED), 16'(n));
    boot(vec);
    bus_rd(6'h23, d);
    chk("reset cause", {ST_RUN, 2'((8'hfe - vec[7:0]) >> 1), !wd_dis, 2'b00}, d);
    $display("t_int vector %h done", vec);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    clk_fail = 1'b0;
    wdog = 1'b0;
    mode_a = 1'b0;
    mode_b = 1'b1;
    rom_nv = 1'b1;
    ee_nv = 1'b0;
    wd_dis = 1'b0;
    ext_low = 1'b0;
    linger = 8'h02;
    addr = 6'h00;
    wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    por(1'b1, 1'b0, 1'b0);
    t_regs();
    t_writes();
    t_int(1'b0, 1'b1, 8'h02, 16'hfffa);
    t_int(1'b1, 1'b0, 8'h02, 16'hfffc);
    t_int(1'b1, 1'b1, 8'h02, 16'hfffc);
    t_int(1'b0, 1'b1, 8'h28, 16'hfffe);
    por(1'b1, 1'b1, 1'b1);
    t_regs();
    por(1'b0, 1'b0, 1'b0);
    t_regs();
    t_int(1'b0, 1'b1, 8'h02, 16'hbffa);
    por(1'b0, 1'b1, 1'b0);
    t_int(1'b1, 1'b0, 8'h02, 16'hbffc);
    end_sim();
  end
endmodule // rsq_reset_init_tb_top

`default_nettype wire
